//--- rtl/dmr_top.sv
`timescale 1ns/1ns
`include "dmr_map.svh"
module dmr_top
  import dmr_pkg::*;
#(
  parameter int NUM_CH = `DMR_NUM_CH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [NUM_CH-1:0] engine_burst_set,
  input wire logic [NUM_CH-1:0] engine_burst_clr,
  output logic [31:0] prdata,
  output logic [31:0] primary_table_address,
  output logic [31:0] alternate_table_address,
  output logic [NUM_CH-1:0] per_channel_soft_trigger,
  output logic [NUM_CH-1:0] burst_only
);
  dmr_chan_if #(.NUM_CH(NUM_CH)) cif ();

  dmr_sel_t sel;
  logic wr_en;
  logic rd_setup;
  logic [31:0] pri_d, pri_q;
  logic [31:0] alt_d, alt_q;
  logic [31:0] rdata_d, rdata_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (paddr)
      `DMR_OFS_PRIMARY: sel = DMR_SEL_PRI;
      `DMR_OFS_ALTERNATE: sel = DMR_SEL_ALT;
      `DMR_OFS_SW_REQUEST: sel = DMR_SEL_SWREQ;
      `DMR_OFS_BURST_SET: sel = DMR_SEL_BSET;
      `DMR_OFS_BURST_CLR: sel = DMR_SEL_BCLR;
      default: sel = DMR_SEL_NONE;
    endcase
  end

  // Writes land in the access phase; reads are fetched in setup
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // ----------------------------------------------------------------
  // Pointer registers
  // ----------------------------------------------------------------
  // Alternate base follows primary one cycle later, never written
  always_comb begin
    pri_d = pri_q;
    if (wr_en && sel == DMR_SEL_PRI) begin
      pri_d = pwdata & `DMR_PRI_MASK;
    end
    alt_d = pri_q + (`DMR_ENTRY_BYTES * 32'(NUM_CH));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pri_q <= `DMR_RST_PRIMARY;
      alt_q <= 32'h0000_0000;
    end else begin
      pri_q <= pri_d;
      alt_q <= alt_d;
    end
  end

  // ----------------------------------------------------------------
  // Channel bit strobes
  // ----------------------------------------------------------------
  assign cif.swreq_wr = wr_en && sel == DMR_SEL_SWREQ;
  assign cif.bset_wr = wr_en && sel == DMR_SEL_BSET;
  assign cif.bclr_wr = wr_en && sel == DMR_SEL_BCLR;
  assign cif.wdata = pwdata[NUM_CH-1:0];
  assign cif.hw_set = engine_burst_set;
  assign cif.hw_clr = engine_burst_clr;

  dmr_chan_bits #(.NUM_CH(NUM_CH)) u_bits (
    .clk(clk),
    .rstn(rstn),
    .cb(cif.bits)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Write-only and unmapped words read zero, reads have no side effect
  always_comb begin
    rdata_d = rdata_q;
    if (rd_setup) begin
      rdata_d = 32'h0000_0000;
      unique case (sel)
        DMR_SEL_PRI: rdata_d = pri_q;
        DMR_SEL_ALT: rdata_d = alt_q;
        DMR_SEL_BSET: rdata_d = 32'(cif.burst_only);
        DMR_SEL_SWREQ: rdata_d = 32'h0000_0000;
        DMR_SEL_BCLR: rdata_d = 32'h0000_0000;
        DMR_SEL_NONE: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  assign primary_table_address = pri_q;
  assign alternate_table_address = alt_q;
  assign per_channel_soft_trigger = cif.trigger;
  assign burst_only = cif.burst_only;
endmodule

//--- rtl/dmr_map.svh
`ifndef DMR_MAP_SVH
`define DMR_MAP_SVH
// How it works
// - Alternate pointer is read-only over all 32 bits and returns alternate table base.
// - Writing one to a soft-trigger bit raises one transfer request on that channel.
// - Writing zero to a soft-trigger bit leaves that channel untouched.
// - Soft-trigger register is write-only; bit n drives channel n, channels 0 to 31.
// - Primary pointer keeps bits 31 to 10; bits 9 to 0 read zero.
// - Writing one to a burst-only bit disables single requests; zero does nothing.

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DMR_OFS_PRIMARY 8'h08
`define DMR_OFS_ALTERNATE 8'h0C
`define DMR_OFS_SW_REQUEST 8'h14
`define DMR_OFS_BURST_SET 8'h18
`define DMR_OFS_BURST_CLR 8'h1C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DMR_PRI_LSB 10
`define DMR_PRI_MASK 32'hFFFF_FC00
`define DMR_RST_PRIMARY 32'h0000_0000
`define DMR_RST_BURST 32'h0000_0000
// Bytes of control data per channel in the primary table
`define DMR_ENTRY_BYTES 32'h0000_0010
`define DMR_NUM_CH 32
`endif

//--- rtl/dmr_pkg.sv
package dmr_pkg;
  // Decoded register selected by the bus address
  typedef enum logic [2:0] {
    DMR_SEL_NONE = 3'b000,
    DMR_SEL_PRI = 3'b001,
    DMR_SEL_ALT = 3'b010,
    DMR_SEL_SWREQ = 3'b011,
    DMR_SEL_BSET = 3'b100,
    DMR_SEL_BCLR = 3'b101
  } dmr_sel_t;
endpackage

//--- rtl/dmr_chan_if.sv
`timescale 1ns/1ns
interface dmr_chan_if #(parameter int NUM_CH = 32);
  logic swreq_wr;
  logic bset_wr;
  logic bclr_wr;
  logic [NUM_CH-1:0] wdata;
  logic [NUM_CH-1:0] hw_set;
  logic [NUM_CH-1:0] hw_clr;
  logic [NUM_CH-1:0] trigger;
  logic [NUM_CH-1:0] burst_only;
  modport ctl (output swreq_wr, output bset_wr, output bclr_wr, output wdata,
    output hw_set, output hw_clr, input trigger, input burst_only);
  modport bits (input swreq_wr, input bset_wr, input bclr_wr, input wdata,
    input hw_set, input hw_clr, output trigger, output burst_only);
endinterface

//--- rtl/dmr_chan_bits.sv
`timescale 1ns/1ns
`include "dmr_map.svh"
module dmr_chan_bits
  import dmr_pkg::*;
#(
  parameter int NUM_CH = `DMR_NUM_CH
) (
  input wire logic clk,
  input wire logic rstn,
  dmr_chan_if.bits cb
);
  logic [NUM_CH-1:0] trig_d, trig_q;
  logic [NUM_CH-1:0] burst_d, burst_q;

  // ----------------------------------------------------------------
  // Per-channel request pulse and burst-only flag
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    // Pulse lasts one cycle so a single write never queues twice
    always_comb begin
      trig_d[ch] = cb.swreq_wr & cb.wdata[ch];
    end
    // Any set source beats a clear in the same cycle
    always_comb begin
      burst_d[ch] = burst_q[ch];
      if (cb.hw_clr[ch] | (cb.bclr_wr & cb.wdata[ch])) begin
        burst_d[ch] = 1'b0;
      end
      if (cb.hw_set[ch] | (cb.bset_wr & cb.wdata[ch])) begin
        burst_d[ch] = 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trig_q <= '0;
      burst_q <= NUM_CH'(`DMR_RST_BURST);
    end else begin
      trig_q <= trig_d;
      burst_q <= burst_d;
    end
  end

  assign cb.trigger = trig_q;
  assign cb.burst_only = burst_q;
endmodule

//--- tb/dmr_monitor.sv
`timescale 1ns/1ns
module dmr_monitor #(parameter int NUM_CH = 32) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [NUM_CH-1:0] engine_burst_set,
  input wire logic [NUM_CH-1:0] engine_burst_clr,
  input wire logic [31:0] prdata,
  input wire logic [31:0] primary_table_address,
  input wire logic [31:0] alternate_table_address,
  input wire logic [NUM_CH-1:0] per_channel_soft_trigger,
  input wire logic [NUM_CH-1:0] burst_only
);
  // ----------------------------------------
  // Bus strobes and properties
  // ----------------------------------------
  wire wr = psel && penable && pwrite;
  wire rs = psel && !penable && !pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_ALT_RO: assert property (wr && paddr == 8'h0C |=> $stable(primary_table_address))
    else $error("alternate write changed pointers");
  AST_TRIG_PULSE: assert property (wr && paddr == 8'h14 |=>
    per_channel_soft_trigger == $past(pwdata)) else $error("bad trigger");
  AST_TRIG_IDLE: assert property (!(wr && paddr == 8'h14) |=>
    per_channel_soft_trigger == '0) else $error("stray trigger");
  AST_SWREQ_WO: assert property (rs && paddr == 8'h14 |=> prdata == 32'h0000_0000)
    else $error("request register readable");
  AST_PRI_ALIGN: assert property (primary_table_address[9:0] == 10'h000)
    else $error("primary low bits set");
  AST_BURST_SET: assert property (wr && paddr == 8'h18 && engine_burst_clr == '0 |=>
    burst_only == ($past(burst_only) | $past(pwdata) | $past(engine_burst_set)))
    else $error("burst set wrong");
  AST_ALT_OFFS: assert property (1'b1 |=>
    alternate_table_address == $past(primary_table_address) + 32'h0000_0200)
    else $error("alternate offset wrong");
  cover property (wr && paddr == 8'h14 && pwdata != 32'h0000_0000);
  cover property (wr && paddr == 8'h18);
  cover property (rs && paddr == 8'h0C);
endmodule
bind dmr_top dmr_monitor #(.NUM_CH(NUM_CH)) u_mon (.*);

//--- tb/dmr_engine_model.sv
`timescale 1ns/1ns
module dmr_engine_model #(parameter int NUM_CH = 32) (
  input wire logic clk,
  input wire logic en,
  output logic [NUM_CH-1:0] set_o,
  output logic [NUM_CH-1:0] clr_o
);
  // Sparse engine hints; silent when off so register checks stay exact
  initial {set_o, clr_o} = '0;
  always @(posedge clk) begin
    set_o <= en ? NUM_CH'($urandom & $urandom & $urandom) : '0;
    clr_o <= en ? NUM_CH'($urandom & $urandom) : '0;
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clk, rstn, psel, penable, pwrite, eng_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pri, alt, trig, bo, es, ec, d, r, m;
  int n_errors, num_checks;
  dmr_top dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .engine_burst_set(es), .engine_burst_clr(ec), .prdata, .primary_table_address(pri),
    .alternate_table_address(alt), .per_channel_soft_trigger(trig), .burst_only(bo));
  dmr_engine_model eng (.clk, .en(eng_en), .set_o(es), .clr_o(ec));
  // ----------------------------------------
  // Clock, helpers and sequence
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] f_alt(input logic [31:0] v);
    return (v & 32'hFFFF_FC00) + 32'h0000_0200;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // Setup, access, release; read data sampled once the fetch edge settles
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1;
    #1 r = prdata;
    @(posedge clk);
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well past the expected few hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    close_out;
  end
  initial begin
    void'($urandom(64483));
    {rstn, psel, penable, pwrite, eng_en} = '0;
    paddr = '0;
    pwdata = '0;
    m = '0;
    repeat (4) @(posedge clk);
    rstn <= 1;
    bus(0, 8'h0C, 0);
    chk(r, 32'h0000_0200);
    bus(0, 8'h40, 0);
    chk(r, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      bus(1, 8'h08, d);
      bus(1, 8'h0C, ~d);
      bus(0, 8'h08, 0);
      chk(r, d & 32'hFFFF_FC00);
      chk(pri, d & 32'hFFFF_FC00);
      bus(0, 8'h0C, 0);
      chk(r, f_alt(d));
      chk(alt, f_alt(d));
      bus(1, 8'h14, d);
      chk(trig, d);
      @(posedge clk);
      #1 chk(trig, 32'h0000_0000);
      bus(0, 8'h14, 0);
      chk(r, 32'h0000_0000);
      m = m | d;
      bus(1, 8'h18, d);
      bus(0, 8'h18, 0);
      chk(r, m);
      d = $urandom;
      m = m & ~d;
      bus(1, 8'h1C, d);
      chk(bo, m);
      bus(0, 8'h1C, 0);
      chk(r, 32'h0000_0000);
    end
    eng_en <= 1;
    repeat (40) bus(1, 8'h14 + 8'(($urandom % 3) * 4), $urandom);
    eng_en <= 0;
    close_out;
  end
endmodule
